//--- option_card_regs.svh
// Reset values, ranges and timing counts for the option card settings logic
`ifndef OPTION_CARD_REGS_SVH
`define OPTION_CARD_REGS_SVH

// ----
// Setting reset values
// ----
`define COMBINE_RESET    1'h0
`define DI_FORMAT_RESET  3'h0
`define ITEM_A_RESET     6'h02
`define ITEM_B_RESET     6'h03
`define GAIN_A_RESET     9'h064
`define GAIN_B_RESET     9'h032
`define BIAS_RESET       8'h00
`define PULSE_MULT_RESET 3'h1

// ----
// Setting ranges
// ----
`define ITEM_MIN         16'h0001
`define ITEM_MAX         16'h0026
`define ITEM_EXCLUDED    39'h0cf2006c10
`define GAIN_MAX         16'h00fa
`define BIAS_LIMIT       16'h0064
`define COMBINE_MAX      16'h0001
`define DI_FORMAT_MAX    16'h0007
`define PULSE_MULT_MAX   16'h0004
`define SCALING_BCD_MIN  8'h02

// ----
// Binary full-scale words
// ----
`define FULL_8BIT        16'h00ff
`define FULL_12BIT       16'h0fff
`define FULL_16BIT       16'h7530

// ----
// Monitor output scale, 0.1 % steps (10 V is 1000)
// ----
`define MON_FULL         16'sh03e8

// ----
// Pulse monitor timing
// ----
`define CLK_HZ           20000000
`define FREQ_STEPS_PER_HZ 100

`endif

//--- option_card_pkg.sv
// Types shared by the option card settings logic
package option_card_pkg;

    // Setting selected by a write
    typedef enum logic [3:0] {
        SET_COMBINE    = 4'h0,
        SET_DI_FORMAT  = 4'h1,
        SET_ITEM_A     = 4'h2,
        SET_GAIN_A     = 4'h3,
        SET_ITEM_B     = 4'h4,
        SET_GAIN_B     = 4'h5,
        SET_BIAS_A     = 4'h6,
        SET_BIAS_B     = 4'h7,
        SET_PULSE_MULT = 4'h8
    } setting_sel_t;

    // Unit of a decoded digital reference
    typedef enum logic [2:0] {
        UNIT_PCT_1   = 3'h0,
        UNIT_PCT_01  = 3'h1,
        UNIT_PCT_001 = 3'h2,
        UNIT_HZ_1    = 3'h3,
        UNIT_HZ_01   = 3'h4,
        UNIT_HZ_001  = 3'h5,
        UNIT_DISPLAY = 3'h6,
        UNIT_BINARY  = 3'h7
    } ref_unit_t;

    // One monitor channel setup
    typedef struct packed {
        logic [5:0]        item;
        logic [8:0]        gain;
        logic signed [7:0] bias;
    } monitor_cfg_t;

    // Decoded digital reference
    typedef struct packed {
        logic [16:0] magnitude;
        logic        negative;
        ref_unit_t   unit;
        logic [15:0] full_scale;
    } digital_ref_t;

endpackage

//--- monitor_scaler.sv
// One analog monitor channel: gain, bias and output range
`timescale 1ns/1ps
`include "option_card_regs.svh"

module monitor_scaler (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire option_card_pkg::monitor_cfg_t cfg_i,
    input  wire logic signed [15:0]           item_value_i,
    input  wire logic                         bipolar_i,
    output logic signed [15:0]                level_o
);
    import option_card_pkg::*;

    logic signed [31:0] scaled;
    logic signed [31:0] biased;
    logic signed [15:0] next_level;

    // ----
    // Gain in hundredths, bias in 0.1 % shifted in 1 % steps
    // ----
    always_comb begin
        scaled = (32'(item_value_i) * $signed({23'h0, cfg_i.gain})) / 32'sd100;
        biased = scaled + 32'(cfg_i.bias) / 32'sd10 * 32'sd10;
        if (biased > 32'(`MON_FULL)) begin
            next_level = `MON_FULL;
        end else if (bipolar_i && biased < -32'(`MON_FULL)) begin
            next_level = -`MON_FULL;
        end else if (!bipolar_i && biased < 32'sd0) begin
            next_level = 16'sh0000;
        end else begin
            next_level = biased[15:0];
        end
    end

    // Output register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_o <= 16'sh0000;
        end else begin
            level_o <= next_level;
        end
    end

endmodule

//--- pulse_monitor_gen.sv
// Square wave at a multiple of the output frequency
`timescale 1ns/1ps
`include "option_card_regs.svh"

module pulse_monitor_gen #(
    parameter int CLK_HZ = `CLK_HZ
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  mult_sel_i,
    input  wire logic [15:0] freq_i,
    output logic             pulse_o
);
    import option_card_pkg::*;

    // Half period expressed in 0.01 Hz clock-steps
    localparam logic [31:0] HALF_LIMIT = 32'(CLK_HZ / 2 * `FREQ_STEPS_PER_HZ);

    logic [31:0] acc;
    logic [31:0] next_acc;
    logic        next_pulse;
    logic [5:0]  mult;
    logic [31:0] step;

    // ----
    // Phase accumulator, toggling each half period
    // ----
    always_comb begin
        unique case (mult_sel_i)
            3'h0: mult = 6'd1;
            3'h1: mult = 6'd6;
            3'h2: mult = 6'd10;
            3'h3: mult = 6'd12;
            default: mult = 6'd36;
        endcase
        step = 32'(freq_i) * 32'(mult);
        next_acc = acc + step;
        next_pulse = pulse_o;
        if (next_acc >= HALF_LIMIT) begin
            next_acc = next_acc - HALF_LIMIT;
            next_pulse = !pulse_o; // 50 % duty
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc <= 32'h0;
            pulse_o <= 1'b0;
        end else begin
            acc <= next_acc;
            pulse_o <= next_pulse;
        end
    end

endmodule

//--- option_card_reference_monitor.sv
// Option card settings, digital reference decode and monitor outputs
//
// Contract
// - Combine 0 separate channels, 1 sums them
// - Lock combine, format, items while running
// - No option/inverter switch with three-channel card
// - Code 7 binary, card full scale is maximum
// - Full scale FF, FFF or 7530 by card
// - Code 6 only with sixteen-bit card
// - Display scaling two up uses its unit
// - Sign plus four digits; code 6 no sign
// - Code 6 lowest digit 2-step, 101-111 nine
// - Items 1-38 minus excluded; defaults 2, 3
// - Gain 0.00-2.50, defaults 1.00, 0.50
// - Bias plus/minus 10 %, 1 % steps
// - Bipolar only on twelve-bit card when selected
// - Pulse multiplier 1, 6, 10, 12, 36
// - Pulse output 50 % duty from Hz
`timescale 1ns/1ps
`include "option_card_regs.svh"

module option_card_reference_monitor (
    input  wire logic                         SYS_CLK_I,
    input  wire logic                         RST_N_I,
    input  wire logic                         RUNNING_I,
    input  wire logic                         WR_EN_I,
    input  wire option_card_pkg::setting_sel_t WR_SEL_I,
    input  wire logic signed [15:0]           WR_DATA_I,
    output logic                              WR_ACK_O,
    output logic                              WR_REJECT_O,
    input  wire logic                         CARD_AI3_I,
    input  wire logic                         CARD_DI16_I,
    input  wire logic                         CARD_DI16_WIDE_I,
    input  wire logic                         CARD_AO12_I,
    input  wire logic signed [13:0]           AIN_CH1_I,
    input  wire logic signed [13:0]           AIN_CH2_I,
    input  wire logic signed [13:0]           AIN_CH3_I,
    input  wire logic [16:0]                  DIN_WORD_I,
    input  wire logic [7:0]                   DISPLAY_SCALING_I,
    input  wire logic                         ANALOG_OUTPUT_LEVEL_SELECT_I,
    input  wire logic signed [15:0]           MON_VALUE_A_I,
    input  wire logic signed [15:0]           MON_VALUE_B_I,
    input  wire logic                         MON_UNIPOLAR_A_I,
    input  wire logic                         MON_UNIPOLAR_B_I,
    input  wire logic [15:0]                  OUT_FREQ_I,
    output logic                              ANALOG_COMBINE_SELECT_O,
    output logic [2:0]                        DIGITAL_INPUT_FORMAT_O,
    output option_card_pkg::monitor_cfg_t     MONITOR_CFG_A_O,
    output option_card_pkg::monitor_cfg_t     MONITOR_CFG_B_O,
    output logic [2:0]                        PULSE_MULTIPLIER_SELECT_O,
    output logic signed [15:0]                AREF_CH1_O,
    output logic signed [15:0]                AREF_CH2_O,
    output logic signed [15:0]                AREF_CH3_O,
    output logic signed [15:0]                AREF_SUM_O,
    output logic                              AREF_SUMMED_O,
    output logic                              MFI_OPTION_SWITCH_ALLOWED_O,
    output option_card_pkg::digital_ref_t     DREF_O,
    output logic signed [15:0]                MON_LEVEL_A_O,
    output logic signed [15:0]                MON_LEVEL_B_O,
    output logic                              PULSE_MONITOR_O
);
    import option_card_pkg::*;

    // ------------------------------------------------------------
    // Synchronisers for card pins and the parallel word
    // ------------------------------------------------------------
    logic [20:0] pin_meta;
    logic [20:0] pin_sync;

    // Two stages, first read only by the second
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            pin_meta <= 21'h0;
            pin_sync <= 21'h0;
        end else begin
            pin_meta <= {CARD_AO12_I, CARD_AI3_I, CARD_DI16_I, CARD_DI16_WIDE_I, DIN_WORD_I};
            pin_sync <= pin_meta;
        end
    end

    logic        ao12_card;
    logic        ai3_card;
    logic        di16_card;
    logic        di16_wide;
    logic [16:0] din_word;

    assign ao12_card = pin_sync[20];
    assign ai3_card  = pin_sync[19];
    assign di16_card = pin_sync[18];
    assign di16_wide = pin_sync[17];
    assign din_word  = pin_sync[16:0];

    // ----
    // Setting store
    // ----
    logic         combine;
    logic [2:0]   di_format;
    monitor_cfg_t cfg_a;
    monitor_cfg_t cfg_b;
    logic [2:0]   pulse_mult;
    logic         next_combine;
    logic [2:0]   next_di_format;
    monitor_cfg_t next_cfg_a;
    monitor_cfg_t next_cfg_b;
    logic [2:0]   next_pulse_mult;
    logic         next_ack;
    logic         next_reject;
    logic         locked;
    logic         in_range;
    logic         item_ok;
    logic [38:0]  excluded;

    // Validate a write and select the new setting values
    always_comb begin
        excluded = `ITEM_EXCLUDED;
        item_ok = (WR_DATA_I >= $signed(`ITEM_MIN)) && (WR_DATA_I <= $signed(`ITEM_MAX))
                  && !excluded[WR_DATA_I[5:0]];
        locked = RUNNING_I && (WR_SEL_I == SET_COMBINE || WR_SEL_I == SET_DI_FORMAT
                 || WR_SEL_I == SET_ITEM_A || WR_SEL_I == SET_ITEM_B);
        unique case (WR_SEL_I)
            SET_COMBINE: begin
                in_range = WR_DATA_I >= 16'sh0 && WR_DATA_I <= $signed(`COMBINE_MAX);
            end
            SET_DI_FORMAT: begin
                in_range = WR_DATA_I >= 16'sh0 && WR_DATA_I <= $signed(`DI_FORMAT_MAX)
                           && (WR_DATA_I != 16'sh6 || di16_card);
            end
            SET_ITEM_A, SET_ITEM_B: begin
                in_range = item_ok;
            end
            SET_GAIN_A, SET_GAIN_B: begin
                in_range = WR_DATA_I >= 16'sh0 && WR_DATA_I <= $signed(`GAIN_MAX);
            end
            SET_BIAS_A, SET_BIAS_B: begin
                in_range = WR_DATA_I >= -$signed(`BIAS_LIMIT)
                           && WR_DATA_I <= $signed(`BIAS_LIMIT);
            end
            SET_PULSE_MULT: begin
                in_range = WR_DATA_I >= 16'sh0 && WR_DATA_I <= $signed(`PULSE_MULT_MAX);
            end
            default: begin
                in_range = 1'b0;
            end
        endcase
        next_ack = WR_EN_I && in_range && !locked;
        next_reject = WR_EN_I && !next_ack;
        next_combine = combine;
        next_di_format = di_format;
        next_cfg_a = cfg_a;
        next_cfg_b = cfg_b;
        next_pulse_mult = pulse_mult;
        if (next_ack) begin
            unique case (WR_SEL_I)
                SET_COMBINE:    next_combine = WR_DATA_I[0];
                SET_DI_FORMAT:  next_di_format = WR_DATA_I[2:0];
                SET_ITEM_A:     next_cfg_a.item = WR_DATA_I[5:0];
                SET_GAIN_A:     next_cfg_a.gain = WR_DATA_I[8:0];
                SET_ITEM_B:     next_cfg_b.item = WR_DATA_I[5:0];
                SET_GAIN_B:     next_cfg_b.gain = WR_DATA_I[8:0];
                SET_BIAS_A:     next_cfg_a.bias = WR_DATA_I[7:0];
                SET_BIAS_B:     next_cfg_b.bias = WR_DATA_I[7:0];
                SET_PULSE_MULT: next_pulse_mult = WR_DATA_I[2:0];
                default:        next_combine = combine;
            endcase
        end
    end

    // Setting registers with documented defaults
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            combine     <= `COMBINE_RESET;
            di_format   <= `DI_FORMAT_RESET;
            cfg_a       <= {`ITEM_A_RESET, `GAIN_A_RESET, `BIAS_RESET};
            cfg_b       <= {`ITEM_B_RESET, `GAIN_B_RESET, `BIAS_RESET};
            pulse_mult  <= `PULSE_MULT_RESET;
            WR_ACK_O    <= 1'b0;
            WR_REJECT_O <= 1'b0;
        end else begin
            combine     <= next_combine;
            di_format   <= next_di_format;
            cfg_a       <= next_cfg_a;
            cfg_b       <= next_cfg_b;
            pulse_mult  <= next_pulse_mult;
            WR_ACK_O    <= next_ack;
            WR_REJECT_O <= next_reject;
        end
    end

    assign ANALOG_COMBINE_SELECT_O   = combine;
    assign DIGITAL_INPUT_FORMAT_O    = di_format;
    assign MONITOR_CFG_A_O           = cfg_a;
    assign MONITOR_CFG_B_O           = cfg_b;
    assign PULSE_MULTIPLIER_SELECT_O = pulse_mult;

    // ----
    // Analog reference channels
    // ----
    logic signed [15:0] next_ch1;
    logic signed [15:0] next_ch2;
    logic signed [15:0] next_ch3;
    logic signed [15:0] next_sum;
    logic               next_allowed;

    // Separate channels, and their sum as the frequency reference when combined
    always_comb begin
        next_ch1 = 16'(AIN_CH1_I);
        next_ch2 = 16'(AIN_CH2_I);
        next_ch3 = 16'(AIN_CH3_I);
        next_sum = combine ? (next_ch1 + next_ch2 + next_ch3) : 16'sh0000;
        next_allowed = !ai3_card;
    end

    // Analog reference registers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            AREF_CH1_O <= 16'sh0000;
            AREF_CH2_O <= 16'sh0000;
            AREF_CH3_O <= 16'sh0000;
            AREF_SUM_O <= 16'sh0000;
            AREF_SUMMED_O <= 1'b0;
            MFI_OPTION_SWITCH_ALLOWED_O <= 1'b0;
        end else begin
            AREF_CH1_O <= next_ch1;
            AREF_CH2_O <= next_ch2;
            AREF_CH3_O <= next_ch3;
            AREF_SUM_O <= next_sum;
            AREF_SUMMED_O <= combine;
            MFI_OPTION_SWITCH_ALLOWED_O <= next_allowed;
        end
    end

    // ------------------------------------------------------------
    // Digital reference decode
    // ------------------------------------------------------------
    digital_ref_t next_dref;
    logic [3:0]   dig3;
    logic [3:0]   dig2;
    logic [3:0]   dig1;
    logic [3:0]   dig0;
    logic [3:0]   low6;
    logic [1:0]   top6;
    logic         special;

    // Weight BCD digits; code 6 with display scaling below 2 uses sign bit as data
    always_comb begin
        special = (di_format == 3'h6) && (DISPLAY_SCALING_I < `SCALING_BCD_MIN);
        top6 = din_word[16:15];
        dig3 = special ? din_word[14:11] : din_word[15:12];
        dig2 = special ? din_word[10:7]  : din_word[11:8];
        dig1 = special ? din_word[6:3]   : din_word[7:4];
        dig0 = din_word[3:0];
        low6 = (din_word[2:0] >= 3'h5) ? 4'h9 : {din_word[2:0], 1'b0};
        next_dref = '0;
        if (di_format == 3'h7) begin
            next_dref.unit = UNIT_BINARY;
            next_dref.magnitude = {1'b0, din_word[15:0]};
            if (!di16_card) begin
                next_dref.full_scale = `FULL_8BIT;
                next_dref.magnitude = {9'h0, din_word[7:0]};
            end else if (di16_wide) begin
                next_dref.full_scale = `FULL_16BIT;
            end else begin
                next_dref.full_scale = `FULL_12BIT;
                next_dref.magnitude = {5'h0, din_word[11:0]};
            end
        end else if (special) begin
            next_dref.unit = UNIT_HZ_001;
            next_dref.magnitude = 17'(top6) * 17'd10000 + 17'(dig3) * 17'd1000
                                  + 17'(dig2) * 17'd100 + 17'(dig1) * 17'd10
                                  + 17'(low6);
        end else begin
            next_dref.negative = din_word[16];
            next_dref.magnitude = 17'(dig3) * 17'd1000 + 17'(dig2) * 17'd100
                                  + 17'(dig1) * 17'd10 + 17'(dig0);
            if (DISPLAY_SCALING_I >= `SCALING_BCD_MIN) begin
                next_dref.unit = UNIT_DISPLAY;
            end else begin
                next_dref.unit = ref_unit_t'(di_format);
            end
        end
    end

    // Decoded reference register
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            DREF_O <= '0;
        end else begin
            DREF_O <= next_dref;
        end
    end

    // ----
    // Monitor channels
    // ----
    logic bipolar_a;
    logic bipolar_b;

    // Bipolar only on the 12-bit card with level select 1
    assign bipolar_a = ao12_card && ANALOG_OUTPUT_LEVEL_SELECT_I && !MON_UNIPOLAR_A_I;
    assign bipolar_b = ao12_card && ANALOG_OUTPUT_LEVEL_SELECT_I && !MON_UNIPOLAR_B_I;

    monitor_scaler u_mon_a (
        .clk_i        (SYS_CLK_I),
        .rst_n_i      (RST_N_I),
        .cfg_i        (cfg_a),
        .item_value_i (MON_VALUE_A_I),
        .bipolar_i    (bipolar_a),
        .level_o      (MON_LEVEL_A_O)
    );

    monitor_scaler u_mon_b (
        .clk_i        (SYS_CLK_I),
        .rst_n_i      (RST_N_I),
        .cfg_i        (cfg_b),
        .item_value_i (MON_VALUE_B_I),
        .bipolar_i    (bipolar_b),
        .level_o      (MON_LEVEL_B_O)
    );

    // ----
    // Pulse monitor
    // ----
    pulse_monitor_gen #(
        .CLK_HZ (`CLK_HZ)
    ) u_pulse (
        .clk_i      (SYS_CLK_I),
        .rst_n_i    (RST_N_I),
        .mult_sel_i (pulse_mult),
        .freq_i     (OUT_FREQ_I),
        .pulse_o    (PULSE_MONITOR_O)
    );

endmodule

//--- option_card_chk.sv
// Port checks for the option card block
`timescale 1ns/1ps
module option_card_chk
    import option_card_pkg::*;
(
    input wire logic                          SYS_CLK_I,
    input wire logic                          RST_N_I,
    input wire logic                          RUNNING_I,
    input wire logic                          WR_EN_I,
    input wire option_card_pkg::setting_sel_t WR_SEL_I,
    input wire logic signed [15:0]            WR_DATA_I,
    input wire logic                          WR_ACK_O,
    input wire logic                          WR_REJECT_O,
    input wire logic                          CARD_AI3_I,
    input wire logic                          CARD_DI16_I,
    input wire option_card_pkg::monitor_cfg_t MONITOR_CFG_A_O,
    input wire logic [2:0]                    DIGITAL_INPUT_FORMAT_O,
    input wire logic signed [15:0]            AREF_SUM_O,
    input wire logic                          AREF_SUMMED_O,
    input wire logic                          MFI_OPTION_SWITCH_ALLOWED_O
);
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    chk_write_answer: assert property (WR_EN_I |=> WR_ACK_O != WR_REJECT_O)
        else $error("no single answer");
    chk_idle_quiet: assert property (!WR_EN_I |=> !WR_ACK_O && !WR_REJECT_O)
        else $error("answer without write");
    chk_lock_refuse: assert property (WR_EN_I && RUNNING_I &&
        WR_SEL_I inside {SET_COMBINE, SET_DI_FORMAT, SET_ITEM_A, SET_ITEM_B} |=> WR_REJECT_O)
        else $error("lock ignored");
    chk_gain_taken: assert property (WR_EN_I && WR_SEL_I == SET_GAIN_A && WR_DATA_I >= 0 &&
        WR_DATA_I <= 250 |=> WR_ACK_O && MONITOR_CFG_A_O.gain == $past(WR_DATA_I[8:0]))
        else $error("gain not applied");
    chk_item_excluded: assert property (WR_EN_I && WR_SEL_I == SET_ITEM_A &&
        WR_DATA_I inside {0, 4, 10, 11, 13, 14, 25, 28, 29, 30, 31, 34, 35} |=> WR_REJECT_O)
        else $error("excluded item accepted");
    chk_reject_keeps: assert property (WR_REJECT_O |-> MONITOR_CFG_A_O == $past(MONITOR_CFG_A_O) &&
        DIGITAL_INPUT_FORMAT_O == $past(DIGITAL_INPUT_FORMAT_O))
        else $error("refusal changed setting");
    chk_sum_idle: assert property (!AREF_SUMMED_O |-> AREF_SUM_O == 16'sh0000)
        else $error("sum without combine");
    chk_mfi_block: assert property (CARD_AI3_I [*4] |-> !MFI_OPTION_SWITCH_ALLOWED_O)
        else $error("switch offered with card");
    chk_fmt6_refused: assert property (!CARD_DI16_I [*4] ##0 (WR_EN_I &&
        WR_SEL_I == SET_DI_FORMAT && WR_DATA_I == 6) |=> WR_REJECT_O)
        else $error("format 6 accepted");
endmodule

bind option_card_reference_monitor option_card_chk u_option_card_chk (.*);

//--- ref_card_model.sv
// Reference card and main controller stand-in
`timescale 1ns/1ps
module ref_card_model (
    input  wire logic signed [13:0] level_i,
    input  wire logic               combine_i,
    output logic signed [13:0]      ch1_o,
    output logic signed [13:0]      ch2_o,
    output logic signed [13:0]      ch3_o,
    output logic [1:0]              source_o
);
    // Three channels follow one level, each different
    assign ch1_o = level_i;
    assign ch2_o = level_i >>> 1;
    assign ch3_o = level_i - 14'sh0010;
    // Option card as source, terminal when summed
    assign source_o = combine_i ? 2'h1 : 2'h3;
endmodule

//--- testbench.sv
// Self-checking bench for the option card settings block
`timescale 1ns/1ps
module testbench;
    import option_card_pkg::*;
    // ----
    // Signals
    // ----
    logic SYS_CLK_I, RST_N_I = 0, RUNNING_I = 0, WR_EN_I = 0, WR_ACK_O, WR_REJECT_O;
    logic CARD_AI3_I = 0, CARD_DI16_I = 0, CARD_DI16_WIDE_I = 0, CARD_AO12_I = 0;
    logic ANALOG_OUTPUT_LEVEL_SELECT_I = 0, MON_UNIPOLAR_A_I = 0, MON_UNIPOLAR_B_I = 0;
    logic ANALOG_COMBINE_SELECT_O, AREF_SUMMED_O, MFI_OPTION_SWITCH_ALLOWED_O, PULSE_MONITOR_O;
    setting_sel_t WR_SEL_I = SET_COMBINE;
    logic signed [15:0] WR_DATA_I = 0, MON_VALUE_A_I = 0, MON_VALUE_B_I = 16'sd400, MON_LEVEL_A_O, MON_LEVEL_B_O;
    logic signed [15:0] AREF_CH1_O, AREF_CH2_O, AREF_CH3_O, AREF_SUM_O;
    logic signed [13:0] AIN_CH1_I, AIN_CH2_I, AIN_CH3_I, lvl = 0;
    logic [16:0] DIN_WORD_I = 0;
    logic [15:0] OUT_FREQ_I = 0;
    logic [7:0] DISPLAY_SCALING_I = 0;
    logic [2:0] DIGITAL_INPUT_FORMAT_O, PULSE_MULTIPLIER_SELECT_O;
    logic [1:0] src;
    monitor_cfg_t MONITOR_CFG_A_O, MONITOR_CFG_B_O;
    digital_ref_t DREF_O;
    int error_cnt = 0, n_tests = 0, cyc = 0;

    option_card_reference_monitor u_option_card_reference_monitor (.*);
    ref_card_model u_ref_card_model (.level_i(lvl), .combine_i(ANALOG_COMBINE_SELECT_O),
        .ch1_o(AIN_CH1_I), .ch2_o(AIN_CH2_I), .ch3_o(AIN_CH3_I), .source_o(src));

    // Clock and hang guard
    initial begin
        SYS_CLK_I = 0;
        forever #25 SYS_CLK_I = ~SYS_CLK_I;
    end
    always @(posedge SYS_CLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            error_cnt++;
            end_sim();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One write and its answer
    task automatic wr(input setting_sel_t s, input int d, input logic ok);
        WR_EN_I = 1;
        WR_SEL_I = s;
        WR_DATA_I = 16'(d);
        @(negedge SYS_CLK_I);
        chk("write_answer", {ok, !ok}, {WR_ACK_O, WR_REJECT_O});
        WR_EN_I = 0;
        @(negedge SYS_CLK_I);
    endtask
    task automatic meas(output int n);
        logic p;
        p = PULSE_MONITOR_O;
        n = 0;
        while (PULSE_MONITOR_O === p && n < 4000) begin
            @(negedge SYS_CLK_I);
            n++;
        end
    endtask
    task automatic settle();
        repeat (3) @(negedge SYS_CLK_I);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_lock();
        chk("cfg_a", {6'h02, 9'h064, 8'h00}, MONITOR_CFG_A_O);
        chk("cfg_b", {6'h03, 9'h032, 8'h00}, MONITOR_CFG_B_O);
        chk("pulse_sel", 3'h1, PULSE_MULTIPLIER_SELECT_O);
        RUNNING_I = 1;
        wr(SET_COMBINE, 1, 0);
        wr(SET_DI_FORMAT, 3, 0);
        wr(SET_ITEM_B, 5, 0);
        wr(SET_GAIN_A, 250, 1);
        wr(SET_BIAS_B, -100, 1);
        RUNNING_I = 0;
    endtask
    task automatic t_ranges();
        int bad[14] = '{0, 4, 10, 11, 13, 14, 25, 28, 29, 30, 31, 34, 35, 39};
        foreach (bad[i]) wr(SET_ITEM_A, bad[i], 0);
        chk("item_a", 6'h02, MONITOR_CFG_A_O.item);
        wr(SET_ITEM_A, 38, 1);
        wr(SET_ITEM_B, 16, 1);
        wr(SET_GAIN_B, 251, 0);
        wr(SET_BIAS_A, 101, 0);
        wr(SET_DI_FORMAT, 8, 0);
        wr(setting_sel_t'(4'h9), 0, 0);
        for (int m = 0; m < 6; m++) wr(SET_PULSE_MULT, m, m < 5);
    endtask
    task automatic t_refs();
        lvl = -14'sd100;
        wr(SET_COMBINE, 1, 1);
        @(negedge SYS_CLK_I);
        chk("sum", 16'shfef6, AREF_SUM_O);
        chk("ch12", {16'shff9c, 16'shffce}, {AREF_CH1_O, AREF_CH2_O});
        chk("ch3", 16'shff8c, AREF_CH3_O);
        wr(SET_DI_FORMAT, 6, 0);
        CARD_DI16_I = 1;
        DIN_WORD_I = 17'h10500;
        wr(SET_DI_FORMAT, 4, 1);
        settle();
        chk("bcd", {17'd500, 1'b1, UNIT_HZ_01}, DREF_O[36:16]);
        wr(SET_DI_FORMAT, 6, 1);
        for (int p = 2; p < 8; p++) begin
            DIN_WORD_I = 17'h091a0 | 17'(p);
            settle();
            chk("bcd5", {17'(p > 4 ? 12349 : 12340 + 2 * p), 1'b0, UNIT_HZ_001}, DREF_O[36:16]);
        end
        CARD_DI16_WIDE_I = 1;
        wr(SET_DI_FORMAT, 7, 1);
        settle();
        chk("fs_wide", {UNIT_BINARY, 16'h7530}, DREF_O[18:0]);
        CARD_DI16_WIDE_I = 0;
        settle();
        chk("fs_12", 16'h0fff, DREF_O.full_scale);
        CARD_DI16_I = 0;
        settle();
        chk("fs_8", 16'h00ff, DREF_O.full_scale);
        DISPLAY_SCALING_I = 8'h02;
        DIN_WORD_I = 17'h01234;
        wr(SET_DI_FORMAT, 4, 1);
        settle();
        chk("scaled", {17'd1234, 1'b0, UNIT_DISPLAY}, DREF_O[36:16]);
    endtask
    task automatic t_monitor();
        MON_VALUE_A_I = 16'sd500;
        wr(SET_BIAS_A, 55, 1);
        chk("mon_clamp", 16'sd1000, MON_LEVEL_A_O);
        chk("mon_b", 16'sd100, MON_LEVEL_B_O);
        CARD_AO12_I = 1;
        wr(SET_GAIN_A, 100, 1);
        chk("mon_a", 16'sd550, MON_LEVEL_A_O);
        MON_VALUE_A_I = -16'sd500;
        ANALOG_OUTPUT_LEVEL_SELECT_I = 1;
        wr(SET_BIAS_A, -100, 1);
        chk("mon_bipolar", -16'sd600, MON_LEVEL_A_O);
        MON_UNIPOLAR_A_I = 1;
        @(negedge SYS_CLK_I);
        chk("mon_unipolar", 16'sd0, MON_LEVEL_A_O);
        MON_UNIPOLAR_A_I = 0;
        CARD_AO12_I = 0;
        settle();
        chk("mon_8bit", 16'sd0, MON_LEVEL_A_O);
        chk("mfi_free", 1'b1, MFI_OPTION_SWITCH_ALLOWED_O);
        CARD_AI3_I = 1;
        repeat (4) @(negedge SYS_CLK_I);
        chk("mfi", 1'b0, MFI_OPTION_SWITCH_ALLOWED_O);
    endtask
    task automatic t_pulse();
        int mul[4] = '{6, 10, 12, 36};
        int hi, lo, q;
        OUT_FREQ_I = 16'd50000;
        for (int s = 1; s < 5; s++) begin
            wr(SET_PULSE_MULT, s, 1);
            q = 1000000000 / (50000 * mul[s - 1]);
            meas(hi);
            meas(hi);
            meas(lo);
            chk("half_period", 1'b1, hi >= q && hi <= q + 1);
            chk("duty", 1'b1, hi - lo <= 1 && lo - hi <= 1);
        end
    endtask
    // Reset, then scenarios
    initial begin
        repeat (5) @(negedge SYS_CLK_I);
        RST_N_I = 1;
        @(negedge SYS_CLK_I);
        t_lock();
        t_ranges();
        t_refs();
        t_monitor();
        t_pulse();
        end_sim();
    end
endmodule
